// ---- src/sdoc_consts.svh ----
// Behaviour
// - Each channel reports a fixed, read-only channel number
// - General output module fault sets 0x01
// - Overload shutdown of a channel sets 0x02
// - Output level readback mismatch sets 0x04
// - Output status readback failure sets 0x08
// - External or protection short circuit sets 0x40
// - Channel off due to own fault sets 0x80
// - Drive value 1 energizes, 0 de-energizes
// - Safety-critical self-test fault latches halt state
// - Halt stops input processing, outputs forced off
`ifndef SDOC_CONSTS_SVH
`define SDOC_CONSTS_SVH

// Channel count and register word offsets (byte addresses)
`define SDOC_NCH            8
`define SDOC_OFF_DRIVE      8'h00
`define SDOC_OFF_STATUS     8'h04
`define SDOC_OFF_IRQ_STAT   8'h08
`define SDOC_OFF_IRQ_MASK   8'h0C
`define SDOC_OFF_CHAN_BASE  8'h20
`define SDOC_OFF_CHAN_LAST  8'h3C

// Error byte codes
`define SDOC_FLT_MODULE     8'h01
`define SDOC_FLT_OVERLOAD   8'h02
`define SDOC_FLT_READBACK   8'h04
`define SDOC_FLT_STATUS_RB  8'h08
`define SDOC_FLT_SHORT      8'h40
`define SDOC_FLT_CHAN_OFF   8'h80

// Fixed channel numbering, first channel number
`define SDOC_CHAN_NUM_BASE  8'h01

// Interrupt status layout: channel bits 7:0, halt bit 8
`define SDOC_IRQ_HALT_BIT   8
`define SDOC_IRQ_W          9

// Readback settle time before a mismatch counts
`define SDOC_CLK_NS         100
`define SDOC_SETTLE_NS      10000
`define SDOC_SETTLE_CYC     ((`SDOC_SETTLE_NS + `SDOC_CLK_NS - 1) / `SDOC_CLK_NS)
`define SDOC_CNT_W          8

`endif

// ---- src/sdoc_pkg.sv ----
package sdoc_pkg;
  // Unit operating state
  typedef enum logic [0:0] {
    SDOC_RUN  = 1'b0,
    SDOC_HALT = 1'b1
  } sdoc_state_t;

  // One channel error byte
  typedef logic [7:0] sdoc_flags_t;
endpackage

// ---- src/sdoc_chan.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "sdoc_consts.svh"
module sdoc_chan
  import sdoc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Control from the unit
  input  wire logic        run,
  input  wire logic        drive_req,
  input  wire logic        rearm,
  // Synchronised diagnostics
  input  wire logic        gen_fault,
  input  wire logic        overload,
  input  wire logic        sense,
  input  wire logic        stat_fail,
  input  wire logic        short_ckt,
  // Results
  output logic             out_on,
  output sdoc_flags_t      flags,
  output logic             new_fault
);

  logic                    ovl_off;
  logic                    flt_off;
  logic [`SDOC_CNT_W-1:0]  settle;
  logic                    next_out_on;
  logic                    next_ovl_off;
  logic                    next_flt_off;
  logic [`SDOC_CNT_W-1:0]  next_settle;
  sdoc_flags_t             next_flags;
  logic                    next_new_fault;
  logic                    mismatch;

  // Next channel state; flags and trips frozen while halted and output forced off, since inputs are not processed
  always_comb begin
    mismatch       = (settle == `SDOC_CNT_W'(`SDOC_SETTLE_CYC)) && (sense != out_on);
    next_ovl_off   = ovl_off;
    next_flt_off   = flt_off;
    next_flags     = flags;
    next_settle    = settle;
    next_new_fault = 1'b0;
    next_out_on    = 1'b0;
    if (run) begin
      // Rearm only succeeds once the cause has gone
      if (rearm && !overload)
        next_ovl_off = 1'b0;
      if (rearm && !short_ckt && !mismatch)
        next_flt_off = 1'b0;
      if (overload)
        next_ovl_off = 1'b1;
      if (short_ckt || mismatch)
        next_flt_off = 1'b1;
      next_out_on = drive_req && !next_ovl_off && !next_flt_off;
      // Readback waits for the pin to settle after each change
      if (next_out_on != out_on)
        next_settle = '0;
      else if (settle != `SDOC_CNT_W'(`SDOC_SETTLE_CYC))
        next_settle = settle + `SDOC_CNT_W'(1);
      next_flags = (gen_fault ? `SDOC_FLT_MODULE : 8'h00)
                 | (next_ovl_off ? `SDOC_FLT_OVERLOAD : 8'h00)
                 | (mismatch ? `SDOC_FLT_READBACK : 8'h00)
                 | (stat_fail ? `SDOC_FLT_STATUS_RB : 8'h00)
                 | (short_ckt ? `SDOC_FLT_SHORT : 8'h00)
                 | ((next_ovl_off || next_flt_off) ? `SDOC_FLT_CHAN_OFF : 8'h00);
      next_new_fault = |(next_flags & ~flags);
    end
  end

  // Channel registers
  always_ff @(posedge clk) begin
    if (rst) begin
      out_on    <= 1'b0;
      ovl_off   <= 1'b0;
      flt_off   <= 1'b0;
      settle    <= '0;
      flags     <= 8'h00;
      new_fault <= 1'b0;
    end else begin
      out_on    <= next_out_on;
      ovl_off   <= next_ovl_off;
      flt_off   <= next_flt_off;
      settle    <= next_settle;
      flags     <= next_flags;
      new_fault <= next_new_fault;
    end
  end

endmodule
`default_nettype wire

// ---- src/sdoc_top.sv ----
// Decided for this implementation: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "sdoc_consts.svh"
module sdoc_top
  import sdoc_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // AHB-Lite slave
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic [31:0]                hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  // Field diagnostics, asynchronous to clk
  input  wire logic                  module_fault,
  input  wire logic                  selftest_fail,
  input  wire logic [`SDOC_NCH-1:0]  overload,
  input  wire logic [`SDOC_NCH-1:0]  out_sense,
  input  wire logic [`SDOC_NCH-1:0]  status_fail,
  input  wire logic [`SDOC_NCH-1:0]  short_ckt,
  // Output drivers and status
  output logic [`SDOC_NCH-1:0]       out_drive,
  output logic                       halted,
  output logic                       irq
);

  localparam int SW = 3 * `SDOC_NCH + `SDOC_NCH + 2;

  // Synchroniser stages
  logic [SW-1:0]               sync1;
  logic [SW-1:0]               sync2;
  logic                        s_module;
  logic                        s_selftest;
  logic [`SDOC_NCH-1:0]        s_overload;
  logic [`SDOC_NCH-1:0]        s_sense;
  logic [`SDOC_NCH-1:0]        s_status;
  logic [`SDOC_NCH-1:0]        s_short;

  // Bus data phase
  logic                        dp_write;
  logic [7:0]                  dp_addr;
  logic                        next_dp_write;
  logic [7:0]                  next_dp_addr;
  logic [31:0]                 next_hrdata;
  logic                        addr_ok;

  // Unit state and registers
  sdoc_state_t                 state;
  sdoc_state_t                 next_state;
  logic [`SDOC_NCH-1:0]        drive;
  logic [`SDOC_NCH-1:0]        next_drive;
  logic [`SDOC_IRQ_W-1:0]      irq_stat;
  logic [`SDOC_IRQ_W-1:0]      irq_mask;
  logic [`SDOC_IRQ_W-1:0]      next_irq_stat;
  logic [`SDOC_IRQ_W-1:0]      next_irq_mask;
  logic [`SDOC_IRQ_W-1:0]      irq_event;
  logic                        next_irq;

  // Per-channel wires
  logic [`SDOC_NCH-1:0]        rearm;
  logic [`SDOC_NCH-1:0]        ch_out;
  logic [`SDOC_NCH-1:0]        ch_new;
  sdoc_flags_t                 ch_flags [`SDOC_NCH];
  logic                        wr_drive;
  logic                        wr_stat;
  logic                        wr_mask;

  // Two flops on every field diagnostic pin before any logic looks at it
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {selftest_fail, module_fault, short_ckt, status_fail, out_sense, overload};
      sync2 <= sync1;
    end
  end

  // Split the second stage into named fields
  assign s_overload = sync2[`SDOC_NCH-1:0];
  assign s_sense    = sync2[2*`SDOC_NCH-1:`SDOC_NCH];
  assign s_status   = sync2[3*`SDOC_NCH-1:2*`SDOC_NCH];
  assign s_short    = sync2[4*`SDOC_NCH-1:3*`SDOC_NCH];
  assign s_module   = sync2[4*`SDOC_NCH];
  assign s_selftest = sync2[4*`SDOC_NCH+1];

  // Address phase accepted only on a valid transfer
  always_comb begin
    next_dp_write = 1'b0;
    next_dp_addr  = dp_addr;
    if (hsel && hready && htrans[1]) begin
      next_dp_write = hwrite;
      next_dp_addr  = haddr[7:0];
    end
  end

  // Read data prepared in the address phase, ready for zero wait states
  always_comb begin
    next_hrdata = 32'h0000_0000;
    addr_ok     = (haddr[31:8] == 24'h00_0000) && (haddr[1:0] == 2'b00);
    if (hsel && hready && htrans[1] && !hwrite && addr_ok) begin
      if (haddr[7:0] == `SDOC_OFF_STATUS) begin
        next_hrdata[0]     = (state == SDOC_HALT);
        next_hrdata[15:8]  = ch_out;
        next_hrdata[23:16] = s_sense;
      end else if (haddr[7:0] == `SDOC_OFF_IRQ_STAT) begin
        next_hrdata[`SDOC_IRQ_W-1:0] = irq_stat;
      end else if (haddr[7:0] == `SDOC_OFF_IRQ_MASK) begin
        next_hrdata[`SDOC_IRQ_W-1:0] = irq_mask;
      end else if (haddr[7:0] >= `SDOC_OFF_CHAN_BASE && haddr[7:0] <= `SDOC_OFF_CHAN_LAST) begin
        // Channel word: fixed number above, error byte below
        next_hrdata[7:0]  = ch_flags[haddr[4:2]];
        next_hrdata[15:8] = `SDOC_CHAN_NUM_BASE + 8'(haddr[4:2]);
      end
      // Drive register is write-only and reads zero
    end
  end

  // Bus registers; always ready, always OKAY
  always_ff @(posedge clk) begin
    if (rst) begin
      dp_write  <= 1'b0;
      dp_addr   <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      dp_write  <= next_dp_write;
      dp_addr   <= next_dp_addr;
      hrdata    <= next_hrdata;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Write strobes in the data phase
  assign wr_drive = dp_write && (dp_addr == `SDOC_OFF_DRIVE);
  assign wr_stat  = dp_write && (dp_addr == `SDOC_OFF_IRQ_STAT);
  assign wr_mask  = dp_write && (dp_addr == `SDOC_OFF_IRQ_MASK);

  // Unit state: halt is entered once and left only by reset
  always_comb begin
    next_state = state;
    if (state == SDOC_RUN && s_selftest)
      next_state = SDOC_HALT;
  end

  always_ff @(posedge clk) begin
    if (rst)
      state <= SDOC_RUN;
    else
      state <= next_state;
  end

  // Drive values; writes are dropped while halted, so no output can return
  always_comb begin
    next_drive = drive;
    rearm      = '0;
    case (state)
      SDOC_RUN: begin
        if (wr_drive) begin
          next_drive = hwdata[`SDOC_NCH-1:0];
          rearm      = ~hwdata[`SDOC_NCH-1:0]; // Writing 0 rearms a tripped channel
        end
      end
      SDOC_HALT: begin
        next_drive = '0;
      end
      default: begin
        next_drive = '0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst)
      drive <= '0;
    else
      drive <= next_drive;
  end

  // One channel slice per output
  genvar gi;
  generate
    for (gi = 0; gi < `SDOC_NCH; gi++) begin : g_ch
      sdoc_chan u_chan (
        .clk       (clk),
        .rst       (rst),
        .run       (state == SDOC_RUN),
        .drive_req (drive[gi]),
        .rearm     (rearm[gi]),
        .gen_fault (s_module),
        .overload  (s_overload[gi]),
        .sense     (s_sense[gi]),
        .stat_fail (s_status[gi]),
        .short_ckt (s_short[gi]),
        .out_on    (ch_out[gi]),
        .flags     (ch_flags[gi]),
        .new_fault (ch_new[gi])
      );
    end
  endgenerate

  // Events: a new error bit per channel, and entry to halt
  always_comb begin
    irq_event                      = '0;
    irq_event[`SDOC_NCH-1:0]       = ch_new;
    irq_event[`SDOC_IRQ_HALT_BIT]  = (state == SDOC_RUN) && (next_state == SDOC_HALT);
  end

  // Sticky status, write one to clear; a same-cycle event wins
  always_comb begin
    next_irq_stat = irq_stat;
    next_irq_mask = irq_mask;
    if (wr_stat)
      next_irq_stat = irq_stat & ~hwdata[`SDOC_IRQ_W-1:0];
    next_irq_stat = next_irq_stat | irq_event;
    if (wr_mask)
      next_irq_mask = hwdata[`SDOC_IRQ_W-1:0];
    next_irq = |(next_irq_stat & next_irq_mask);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_stat <= '0;
      irq_mask <= '0;
      irq      <= 1'b0;
    end else begin
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      irq      <= next_irq;
    end
  end

  // Pin outputs, each from a flop; forced off on the edge entering halt, a cycle before the channel outputs are zero
  always_ff @(posedge clk) begin
    if (rst) begin
      out_drive <= '0;
      halted    <= 1'b0;
    end else begin
      out_drive <= (next_state == SDOC_HALT) ? '0 : ch_out;
      halted    <= (next_state == SDOC_HALT);
    end
  end

endmodule
`default_nettype wire

// ---- bench/sdoc_checker.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "sdoc_consts.svh"
module sdoc_checker (
  // Clock and reset
  input wire logic                 clk,
  input wire logic                 rst,
  // Bus as seen by the unit
  input wire logic                 hsel,
  input wire logic [31:0]          haddr,
  input wire logic [1:0]           htrans,
  input wire logic                 hwrite,
  input wire logic [31:0]          hwdata,
  input wire logic                 hready,
  input wire logic [31:0]          hrdata,
  // Field side
  input wire logic                 selftest_fail,
  input wire logic [`SDOC_NCH-1:0] overload,
  input wire logic [`SDOC_NCH-1:0] short_ckt,
  input wire logic [`SDOC_NCH-1:0] out_drive,
  input wire logic                 halted,
  input wire logic                 irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // Request accepted at this edge, and the channel slot it names
  wire       taken = hsel && hready && htrans[1];
  wire [2:0] slot  = haddr[4:2];

  chk_halt_sticky: assert property (halted |=> halted)
    else $error("halt state left without reset");
  chk_halt_entry: assert property (selftest_fail [*4] |=> halted)
    else $error("self-test fault did not halt the unit");
  chk_halt_off: assert property (halted |-> out_drive == 8'h00)
    else $error("output energized while halted");
  chk_halt_status: assert property (taken && !hwrite && haddr == {24'h0, `SDOC_OFF_STATUS}
    |=> hrdata[0] == $past(halted)) else $error("status halt bit wrong");
  chk_chan_num: assert property (taken && !hwrite && haddr[31:5] == 27'h1 && haddr[1:0] == 2'h0
    |=> hrdata[31:8] == {21'h0, $past(slot)} + 24'h1) else $error("channel number wrong");
  chk_drive_zero: assert property (taken && hwrite && haddr == {24'h0, `SDOC_OFF_DRIVE}
    ##1 hwdata == 32'h0 |-> ##3 out_drive == 8'h00) else $error("zero drive left output on");
  // Eight quiet samples leave room for the two sync flops and the trip
  chk_ovl_off: assert property ($stable(overload) [*8] |=> (out_drive & overload) == 8'h00)
    else $error("overloaded channel still driven");
  chk_short_off: assert property ($stable(short_ckt) [*8] |=> (out_drive & short_ckt) == 8'h00)
    else $error("shorted channel still driven");

  cover property ($rose(halted));
  cover property ($rose(irq));
  cover property (taken && !hwrite && haddr[5]);
endmodule
bind sdoc_top sdoc_checker sdoc_checker_inst (.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .hrdata, .selftest_fail, .overload, .short_ckt, .out_drive, .halted, .irq);
`default_nettype wire

// ---- bench/sdoc_ctl_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module sdoc_ctl_model (
  // Clock
  input  wire logic        clk,
  // Answer from the unit
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  // Requests to the unit
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  // Whole words only
  assign hsize = 3'h2;

  // Bus idle until the first transfer
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
  end

  // Address held until taken, then data held until ready; never assumes latency
  task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask
endmodule
`default_nettype wire

// ---- bench/tb_safe_digital_output_channels.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "sdoc_consts.svh"
module tb_safe_digital_output_channels;
  import sdoc_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        hsel, hwrite, hreadyout, hresp, halted, irq, hlt;
  logic        module_fault, selftest_fail;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [7:0]  overload, status_fail, short_ckt, out_drive, inv, drv, trip;
  logic [7:0]  out_sense = 8'h00;
  int          fails = 0;
  int          n_checks = 0;

  sdoc_top sdoc_top_inst (.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hrdata, .hreadyout, .hresp, .module_fault, .selftest_fail, .overload, .out_sense, .status_fail,
    .short_ckt, .out_drive, .halted, .irq);
  sdoc_ctl_model sdoc_ctl_model_inst (.clk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata);

  always #50 clk = ~clk;
  // Load reads back the driven level, inverted where a fault is injected
  always @(posedge clk) out_sense <= out_drive ^ inv;

  task automatic chk(input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, d);
    sdoc_ctl_model_inst.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [31:0] a);
    sdoc_ctl_model_inst.xfer(1'b0, a, 32'h0, q);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Error byte expected from the faults applied so far
  function automatic logic [7:0] model(input int i);
    return {trip[i], short_ckt[i], 2'h0, status_fail[i], inv[i], overload[i], module_fault};
  endfunction
  // All channel words, the outputs and the halt bit against the model
  task automatic chk_all(input string s);
    for (int i = 0; i < `SDOC_NCH; i++) begin
      rd(`SDOC_OFF_CHAN_BASE + 4 * i);
      chk(q, {16'h0, 8'(i) + `SDOC_CHAN_NUM_BASE, model(i)});
    end
    chk({24'h0, out_drive}, {24'h0, drv & ~trip & {8{~hlt}}});
    rd(`SDOC_OFF_STATUS);
    chk(q & 32'h1, {31'h0, hlt});
    $display("Test %s done", s);
  endtask
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Whole run is under a thousand cycles; three thousand means a hang
  initial begin
    #(3000 * 100);
    fails++;
    report_and_stop();
  end

  initial begin
    {module_fault, selftest_fail, hlt} = 3'h0;
    {overload, status_fail, short_ckt, inv, drv, trip} = '0;
    void'($urandom(88198));
    settle(6);
    rst <= 1'b0;
    settle(1);
    chk({30'h0, hresp, hreadyout}, 32'h1);
    wr(`SDOC_OFF_CHAN_BASE, 32'hFFFF_FFFF);
    rd(32'h80);
    chk(q, 32'h0);
    chk_all("reset");
    // Random drive patterns, last one all off
    for (int k = 0; k < 4; k++) begin
      drv = (k == 3) ? 8'h00 : 8'($urandom);
      wr(`SDOC_OFF_DRIVE, {24'h0, drv});
      settle(3);
      chk_all("drive");
    end
    drv = 8'hFF;
    wr(`SDOC_OFF_DRIVE, 32'hFF);
    {module_fault, status_fail, short_ckt, overload} <= {1'b1, 8'h02, 8'h08, 8'h04};
    trip = 8'h0C;
    settle(8);
    chk_all("faults");
    // Every channel gained an error bit; interrupt follows the mask
    rd(`SDOC_OFF_IRQ_STAT);
    chk(q, 32'hFF);
    chk({31'h0, irq}, 32'h0);
    wr(`SDOC_OFF_IRQ_MASK, 32'h1FF);
    settle(2);
    chk({31'h0, irq}, 32'h1);
    wr(`SDOC_OFF_IRQ_STAT, 32'hFF);
    settle(2);
    chk({31'h0, irq}, 32'h0);
    // Overload gone, then a zero write rearms channel 2 only
    {module_fault, overload} <= 9'h0;
    settle(4);
    wr(`SDOC_OFF_DRIVE, 32'hFB);
    wr(`SDOC_OFF_DRIVE, 32'hFF);
    trip = 8'h08;
    settle(4);
    chk_all("rearm");
    // Mismatch must outlast the settle time twice: before and after the trip
    inv <= 8'h10;
    settle(250);
    trip = 8'h18;
    chk_all("readback");
    selftest_fail <= 1'b1;
    settle(6);
    hlt = 1'b1;
    chk_all("halt");
    {selftest_fail, overload} <= {1'b0, 8'h20};
    wr(`SDOC_OFF_DRIVE, 32'hFF);
    settle(8);
    rd(`SDOC_OFF_CHAN_BASE + 20);
    chk(q, 32'h0600);
    rd(`SDOC_OFF_IRQ_STAT);
    chk(q & 32'h100, 32'h100);
    // Overload drops again so the model matches the frozen flags
    overload <= 8'h00;
    settle(1);
    chk_all("frozen");
    report_and_stop();
  end
endmodule
`default_nettype wire
